// ===== logic/sfp_defines.vh
// Constants for the serial flash programming port: opcodes, register map and timing.
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH

// First instruction bytes.
`define SFP_OP_ENABLE      8'hac
`define SFP_OP_READ_BYTE   8'h20
`define SFP_OP_WRITE_BYTE  8'h40
`define SFP_OP_READ_LOCK   8'h24
`define SFP_OP_READ_PAGE   8'h30
`define SFP_OP_WRITE_PAGE  8'h50

// Second byte patterns under the 8'hac first byte, and the enable answer byte.
`define SFP_ENABLE_KEY     8'h53
`define SFP_ENABLE_ECHO    8'h69
`define SFP_ERASE_TAG      3'h4
`define SFP_LOCK_TAG       6'h38

// Lock status bit position inside the answer byte.
`define SFP_LOCK_POS       2
`define SFP_LAST_OFFSET    8'hff
`define SFP_ERASED_BYTE    8'hff

// Register map, byte addresses.
`define SFP_ADDR_CTRL      12'h000
`define SFP_ADDR_STATUS    12'h004
`define SFP_CTRL_RESET     32'h0000_0001
`define SFP_CTRL_EN_POS    0
`define SFP_ST_ENABLED_POS 0
`define SFP_ST_BUSY_POS    1
`define SFP_ST_LOCK_POS    2

// Timing: self-timed byte write, 25 ns system clock.
`define SFP_WRITE_TIME_NS  1000000
`define SFP_CLK_PERIOD_NS  25
`define SFP_WRITE_CYCLES   (`SFP_WRITE_TIME_NS / `SFP_CLK_PERIOD_NS)

`endif

// ===== logic/sfp_flash_array.v
// Code flash array with self-timed byte write, sequential chip erase and data polling.
`timescale 1ns/10ps
`default_nettype none
`include "sfp_defines.vh"

module sfp_flash_array #(
  parameter ADDR_W       = 13,
  parameter WRITE_CYCLES = `SFP_WRITE_CYCLES
) (
  input  wire              clk_sys,
  input  wire              rst,
  input  wire              wr_en,
  input  wire [ADDR_W-1:0] wr_addr,
  input  wire [7:0]        wr_data,
  input  wire              erase_start,
  input  wire [ADDR_W-1:0] rd_addr,
  output reg  [7:0]        rd_data,
  output reg               busy
);

  localparam DEPTH = 1 << ADDR_W;

  reg [7:0]        mem [0:DEPTH-1];
  reg [31:0]       timer_reg;
  reg              erasing_reg;
  reg [ADDR_W-1:0] erase_cnt_reg;
  reg [ADDR_W-1:0] last_addr_reg;
  reg              wr_busy_reg;

  // Array port: erase sweeps one location a cycle, else byte writes land at once.
  always @(posedge clk_sys) begin
    if (erasing_reg) begin
      mem[erase_cnt_reg] <= `SFP_ERASED_BYTE;
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // A read of the byte still being written shows its top bit inverted for polling.
  always @(posedge clk_sys) begin
    if (wr_busy_reg && rd_addr == last_addr_reg) begin
      rd_data <= mem[rd_addr] ^ 8'h80;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

  // Write timer runs on its own, no shift clock needed; a new write restarts it.
  always @(posedge clk_sys) begin
    if (rst) begin
      timer_reg     <= 32'h0000_0000;
      wr_busy_reg   <= 1'b0;
      last_addr_reg <= {ADDR_W{1'b0}};
      erasing_reg   <= 1'b0;
      erase_cnt_reg <= {ADDR_W{1'b0}};
      busy          <= 1'b0;
    end else begin
      if (wr_en && !erasing_reg) begin
        timer_reg     <= WRITE_CYCLES - 1;
        wr_busy_reg   <= 1'b1;
        last_addr_reg <= wr_addr;
      end else if (timer_reg != 32'h0000_0000) begin
        timer_reg <= timer_reg - 32'h0000_0001;
      end else begin
        wr_busy_reg <= 1'b0;
      end
      if (erase_start) begin
        erasing_reg   <= 1'b1;
        erase_cnt_reg <= {ADDR_W{1'b0}};
      end else if (erasing_reg) begin
        erase_cnt_reg <= erase_cnt_reg + 1'b1;
        if (&erase_cnt_reg) begin
          erasing_reg <= 1'b0;
        end
      end
      busy <= wr_busy_reg | erasing_reg | erase_start | wr_en;
    end
  end

endmodule // sfp_flash_array
`default_nettype wire

// ===== logic/sfp_prog_port.v
// Serial flash programming port: pin receiver, instruction decoder and APB status slave.
//
// How it works
// - Enable is ac 53 xx xx; with reset pin high, fourth byte answers 69.
// - ac with second byte 100xxxxx erases the whole code array.
// - Opcode 20 reads byte at A12..A8 from byte two, A7..A0 from three.
// - Opcode 40 writes byte four to the 13-bit address from bytes two, three.
// - ac with second byte 111000xx writes lock select bits from its low bits.
// - Select 00 no lock, 01 lock bit 1, 10 lock bit 2, 11 lock bit 3.
// - Opcode 24 returns current lock bit states in byte four.
// - Programmed lock bits read back as one, unprogrammed as zero.
// - Opcode 30 takes page A12..A8 and shifts out all 256 page bytes.
// - Opcode 50 takes page A12..A8 and programs 256 following data bytes.
// - Page transfers run from offset 0 through offset 255 in order.
// - After page header every byte is data until 256 moved, then decode resumes.
// - Programming state is entered by reset held high, no pulse needed.
// - During a byte write, reading that byte returns its top bit inverted.
// - Each byte write is internally timed, no further shift clocks needed.
`timescale 1ns/10ps
`default_nettype none
`include "sfp_defines.vh"

module sfp_prog_port #(
  parameter ADDR_W       = 13,
  parameter WRITE_CYCLES = `SFP_WRITE_CYCLES
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        prog_reset_pin,
  input  wire        sck,
  input  wire        mosi,
  output reg         miso,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr
);

  localparam ST_IDLE = 3'b001;
  localparam ST_CMD  = 3'b010;
  localparam ST_PAGE = 3'b100;

  // Two-stage synchronisers for the pins; stage one feeds stage two only.
  reg [2:0] sync1_reg;
  reg [2:0] sync2_reg;
  reg       sck_prev_reg;
  wire      prog_pin_s = sync2_reg[0];
  wire      sck_s      = sync2_reg[1];
  wire      mosi_s     = sync2_reg[2];

  always @(posedge clk_sys) begin
    if (rst) begin
      sync1_reg    <= 3'h0;
      sync2_reg    <= 3'h0;
      sck_prev_reg <= 1'b0;
    end else begin
      sync1_reg    <= {mosi, sck, prog_reset_pin};
      sync2_reg    <= sync1_reg;
      sck_prev_reg <= sck_s;
    end
  end

  wire sck_rise = sck_s & ~sck_prev_reg;

  reg [2:0]        state_reg;
  reg [2:0]        bit_cnt_reg;
  reg [6:0]        in_shift_reg;
  reg [7:0]        out_shift_reg;
  reg [1:0]        byte_idx_reg;
  reg [7:0]        op_reg;
  reg [7:0]        b2_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg [7:0]        offset_reg;
  reg              enabled_reg;
  reg [2:0]        lock_reg;
  reg [1:0]        load_dly_reg;
  reg              wr_en_reg;
  reg [7:0]        wr_data_reg;
  reg              erase_reg;
  reg              ctrl_en_reg;
  wire [7:0]       flash_rd;
  wire             flash_busy;
  reg [ADDR_W-1:0] wr_addr_q;

  // Software may withdraw the port; it then behaves as if the reset pin were low.
  wire port_on = prog_pin_s & ctrl_en_reg;
  wire byte_done = sck_rise && bit_cnt_reg == 3'h7;
  wire [7:0] rx_byte = {in_shift_reg, mosi_s};
  wire page_op = op_reg == `SFP_OP_READ_PAGE || op_reg == `SFP_OP_WRITE_PAGE;

  // Answer byte chosen after the flash read has had two cycles to settle.
  reg [7:0] answer;
  always @* begin
    if (op_reg == `SFP_OP_ENABLE) begin
      answer = `SFP_ENABLE_ECHO;
    end else if (op_reg == `SFP_OP_READ_LOCK) begin
      answer = {3'h0, lock_reg, 2'h0} ;
    end else begin
      answer = flash_rd;
    end
  end

  // Bit engine and decoder share one process so byte ends and loads never race.
  always @(posedge clk_sys) begin
    if (rst) begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 3'h0;
      in_shift_reg  <= 7'h00;
      out_shift_reg <= 8'h00;
      byte_idx_reg  <= 2'h0;
      op_reg        <= 8'h00;
      b2_reg        <= 8'h00;
      addr_reg      <= {ADDR_W{1'b0}};
      offset_reg    <= 8'h00;
      enabled_reg   <= 1'b0;
      lock_reg      <= 3'h0;
      load_dly_reg  <= 2'h0;
      wr_en_reg     <= 1'b0;
      wr_data_reg   <= 8'h00;
      erase_reg     <= 1'b0;
      miso          <= 1'b0;
    end else begin
      wr_en_reg    <= 1'b0;
      erase_reg    <= 1'b0;
      load_dly_reg <= {load_dly_reg[0], 1'b0};
      miso         <= out_shift_reg[7];
      if (load_dly_reg[1]) begin
        out_shift_reg <= answer;
      end else if (sck_rise) begin
        out_shift_reg <= {out_shift_reg[6:0], 1'b0};
      end
      if (sck_rise) begin
        in_shift_reg <= rx_byte[6:0];
        bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      end
      case (state_reg)
        ST_IDLE: begin
          // Reset pin held high is all it takes; no pulse sequence is needed.
          bit_cnt_reg   <= 3'h0;
          byte_idx_reg  <= 2'h0;
          enabled_reg   <= 1'b0;
          out_shift_reg <= 8'h00;
          if (port_on) begin
            state_reg <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (!port_on) begin
            state_reg <= ST_IDLE;
          end else if (byte_done) begin
            byte_idx_reg <= byte_idx_reg + 2'h1;
            case (byte_idx_reg)
              2'h0: begin
                op_reg <= rx_byte;
              end
              2'h1: begin
                b2_reg   <= rx_byte;
                addr_reg <= {rx_byte[ADDR_W-9:0], addr_reg[7:0]};
                if (page_op && enabled_reg) begin
                  // Page header latched: everything after is data from offset 0.
                  state_reg    <= ST_PAGE;
                  byte_idx_reg <= 2'h0;
                  offset_reg   <= 8'h00;
                  addr_reg     <= {rx_byte[ADDR_W-9:0], 8'h00};
                  if (op_reg == `SFP_OP_READ_PAGE) begin
                    load_dly_reg <= 2'h1;
                  end
                end
              end
              2'h2: begin
                addr_reg <= {addr_reg[ADDR_W-1:8], rx_byte};
                if (op_reg == `SFP_OP_ENABLE && b2_reg == `SFP_ENABLE_KEY) begin
                  load_dly_reg <= 2'h1;
                end else if (enabled_reg && (op_reg == `SFP_OP_READ_BYTE ||
                                             op_reg == `SFP_OP_READ_LOCK)) begin
                  load_dly_reg <= 2'h1;
                end
              end
              default: begin
                if (op_reg == `SFP_OP_ENABLE && b2_reg == `SFP_ENABLE_KEY) begin
                  enabled_reg <= 1'b1;
                end else if (!enabled_reg) begin
                  enabled_reg <= 1'b0;
                end else if (op_reg == `SFP_OP_ENABLE && b2_reg[7:5] == `SFP_ERASE_TAG) begin
                  // Erase also clears the lock bits so a locked part can be reused.
                  erase_reg <= 1'b1;
                  lock_reg  <= 3'h0;
                end else if (op_reg == `SFP_OP_ENABLE && b2_reg[7:2] == `SFP_LOCK_TAG) begin
                  // Bit 1 is lock_select_high, bit 0 lock_select_low; bits only accumulate.
                  case (b2_reg[1:0])
                    2'h1:    lock_reg[0] <= 1'b1;
                    2'h2:    lock_reg[1] <= 1'b1;
                    2'h3:    lock_reg[2] <= 1'b1;
                    default: lock_reg    <= lock_reg;
                  endcase
                end else if (op_reg == `SFP_OP_WRITE_BYTE) begin
                  wr_en_reg   <= 1'b1;
                  wr_data_reg <= rx_byte;
                end
              end
            endcase
          end
        end
        ST_PAGE: begin
          if (!port_on) begin
            state_reg <= ST_IDLE;
          end else if (byte_done) begin
            offset_reg <= offset_reg + 8'h01;
            if (op_reg == `SFP_OP_WRITE_PAGE) begin
              wr_en_reg   <= 1'b1;
              wr_data_reg <= rx_byte;
            end
            if (offset_reg == `SFP_LAST_OFFSET) begin
              state_reg <= ST_CMD;
            end else if (op_reg == `SFP_OP_READ_PAGE) begin
              load_dly_reg <= 2'h1;
            end
          end
          // At a byte end the read address jumps to the next offset, so the flash read and the
          // two-cycle answer delay fetch the byte shifted out next rather than the one just sent.
          if (byte_done) begin
            addr_reg <= {addr_reg[ADDR_W-1:8], offset_reg + 8'h01};
          end else begin
            addr_reg <= {addr_reg[ADDR_W-1:8], offset_reg};
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // The flash write address is the latched one; the page offset is registered in it.
  sfp_flash_array #(
    .ADDR_W       (ADDR_W),
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_flash (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .wr_en       (wr_en_reg),
    .wr_addr     (wr_addr_q),
    .wr_data     (wr_data_reg),
    .erase_start (erase_reg),
    .rd_addr     (addr_reg),
    .rd_data     (flash_rd),
    .busy        (flash_busy)
  );

  // Write address captured with the byte so the page offset advance cannot skew it.
  always @(posedge clk_sys) begin
    if (rst) begin
      wr_addr_q <= {ADDR_W{1'b0}};
    end else if (byte_done) begin
      wr_addr_q <= (state_reg == ST_PAGE) ? {addr_reg[ADDR_W-1:8], offset_reg} : addr_reg;
    end
  end

  // APB slave: answers in the second access cycle, unmapped addresses flag an error.
  wire apb_setup = psel & ~penable;
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_en_reg <= 1'b1;
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel & penable & ~pready) begin
        prdata <= 32'h0000_0000;
        if (paddr == `SFP_ADDR_CTRL) begin
          if (pwrite) begin
            ctrl_en_reg <= pwdata[`SFP_CTRL_EN_POS];
          end else begin
            prdata[`SFP_CTRL_EN_POS] <= ctrl_en_reg;
          end
        end else if (paddr == `SFP_ADDR_STATUS) begin
          if (!pwrite) begin
            prdata[`SFP_ST_ENABLED_POS]                    <= enabled_reg;
            prdata[`SFP_ST_BUSY_POS]                       <= flash_busy;
            prdata[`SFP_ST_LOCK_POS+2:`SFP_ST_LOCK_POS]    <= lock_reg;
          end
        end else begin
          pslverr <= 1'b1;
        end
      end else if (apb_setup) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule // sfp_prog_port
`default_nettype wire

// ===== tb/sfp_prog_checker.sv
// Port-level assertions for the serial flash programming port, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
`include "sfp_defines.vh"
module sfp_prog_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        prog_reset_pin,
  input wire logic        sck,
  input wire logic        mosi,
  input wire logic        miso,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic       sck_q;
  logic [3:0] rise_age;
  logic [3:0] high_age;
  logic [3:0] low_age;
  wire        mapped = (paddr == `SFP_ADDR_CTRL) || (paddr == `SFP_ADDR_STATUS);

  // Ages of the last raw shift clock rise and of the pin level; they saturate so they never wrap.
  always_ff @(posedge clk_sys) begin
    sck_q <= sck;
    if (rst) begin
      rise_age <= 4'hf;
      high_age <= 4'h0;
      low_age  <= 4'h0;
    end else begin
      rise_age <= (sck && !sck_q) ? 4'h0 : (rise_age == 4'hf) ? 4'hf : rise_age + 4'h1;
      high_age <= !prog_reset_pin ? 4'h0 : (high_age == 4'hf) ? 4'hf : high_age + 4'h1;
      low_age  <= prog_reset_pin ? 4'h0 : (low_age == 4'hf) ? 4'hf : low_age + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after exactly one wait state");
  chk_rdy_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_rdy_cause: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside an access phase");
  chk_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access without slave error");
  chk_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("slave error on a mapped register");
  chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  chk_ctrl_rsvd: assert property (pready && !pwrite && paddr == `SFP_ADDR_CTRL |-> prdata[31:1] == 31'h0)
    else $error("control read has reserved bits set");
  chk_stat_rsvd: assert property (pready && !pwrite && paddr == `SFP_ADDR_STATUS |-> prdata[31:5] == 27'h0)
    else $error("status read has reserved bits set");
  chk_stat_off: assert property (pready && !pwrite && paddr == `SFP_ADDR_STATUS && low_age == 4'hf |-> !prdata[0])
    else $error("programming still enabled with reset pin low");
  chk_miso_idle: assert property (low_age == 4'hf |-> !miso)
    else $error("serial output active with reset pin low");
  chk_miso_edge: assert property ($changed(miso) && high_age == 4'hf |-> rise_age <= 4'ha)
    else $error("serial output moved away from a shift clock rise");

  cover property (pready && pslverr);
  cover property (pready && !pwrite && paddr == `SFP_ADDR_STATUS && prdata[4:2] == 3'h7);
  cover property ($changed(miso) && high_age == 4'hf);
endmodule // sfp_prog_checker

bind sfp_prog_port sfp_prog_checker u_chk (
  .clk_sys(clk_sys), .rst(rst), .prog_reset_pin(prog_reset_pin), .sck(sck), .mosi(mosi), .miso(miso),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr)
);
`default_nettype wire

// ===== tb/sfp_prog_model.sv
// Behavioural model of the external programmer that shifts instructions over the serial pins.
`timescale 1ns/10ps
`default_nettype none
module sfp_prog_model (
  input  wire logic clk_sys,
  output logic      sck,
  output logic      mosi,
  input  wire logic miso
);
  // Shift clock rests low between frames.
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
  end

  // One byte, MSB first, eight system clocks low then eight high, so the rate is exactly the limit.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk_sys);
      mosi <= tx[i];
      repeat (7) @(posedge clk_sys);
      sck <= 1'b1;
      rx[i] = miso;
      repeat (8) @(posedge clk_sys);
      sck <= 1'b0;
    end
    mosi <= ~tx[0]; // A stale bit must not look valid between frames.
  endtask

  // A four-byte instruction; the answer of the fourth byte is handed back.
  task automatic instr(input logic [31:0] w, output logic [7:0] r);
    for (int b = 3; b >= 0; b--) xfer(w[b*8+:8], r);
  endtask
endmodule // sfp_prog_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the serial flash programming port.
`timescale 1ns/10ps
`default_nettype none
`include "sfp_defines.vh"
module tb_top;
  localparam int WCYC = 2000;
  localparam logic [11:0] ST = `SFP_ADDR_STATUS;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        pin = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, sck, mosi, miso;
  logic [7:0]  r;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cycles = 0;

  // System clock at 40 MHz.
  always #12.5 clk_sys = ~clk_sys;

  sfp_prog_port #(.WRITE_CYCLES(WCYC)) dut (.clk_sys(clk_sys), .rst(rst), .prog_reset_pin(pin), .sck(sck),
    .mosi(mosi), .miso(miso), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sfp_prog_model prog (.clk_sys(clk_sys), .sck(sck), .mosi(mosi), .miso(miso));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: value mismatch, seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] xd, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, xd);
    chk(e, xe);
  endtask

  task automatic wrc(input logic [11:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk(e, xe);
  endtask

  // Polls the busy flag; only the run's timeout bounds this wait.
  task automatic idle;
    logic [31:0] q;
    logic e;
    do apb(1'b0, ST, 32'h0, q, e); while (q[1] !== 1'b0);
  endtask

  task automatic ins(input logic [31:0] w, input logic [7:0] x);
    prog.instr(w, r);
    chk(r, x);
  endtask

  task automatic t_regs;
    rdc(`SFP_ADDR_CTRL, 32'h1, 1'b0);
    rdc(ST, 32'h0, 1'b0);
    wrc(ST, 32'hff, 1'b0);
    rdc(ST, 32'h0, 1'b0);
    wrc(`SFP_ADDR_CTRL, 32'h1, 1'b0);
    rdc(12'h008, 32'h0, 1'b1);
    wrc(12'h00c, 32'h0, 1'b1);
  endtask

  task automatic t_enable;
    @(posedge clk_sys) pin <= 1'b1;
    repeat (64) @(posedge clk_sys);
    ins(32'hac520000, 8'h00);
    ins(32'h20000000, 8'h00);
    rdc(ST, 32'h0, 1'b0);
    ins(32'hac530000, `SFP_ENABLE_ECHO);
    rdc(ST, 32'h1, 1'b0);
  endtask

  task automatic t_erase;
    prog.instr(32'hac9f0000, r);
    idle();
    ins(32'h20ffff00, 8'hff);
  endtask

  task automatic t_byte;
    prog.instr(32'h40ff34a5, r);
    ins(32'h20ff3400, 8'h25);
    rdc(ST, 32'h3, 1'b0);
    idle();
    ins(32'h201f3400, 8'ha5);
  endtask

  task automatic t_page;
    prog.xfer(`SFP_OP_WRITE_PAGE, r);
    prog.xfer(8'he5, r);
    for (int i = 0; i < 256; i++) prog.xfer(8'(i) ^ 8'h3c, r);
    idle();
    prog.xfer(`SFP_OP_READ_PAGE, r);
    prog.xfer(8'h05, r);
    for (int i = 0; i < 256; i++) begin
      prog.xfer(8'h00, r);
      chk(r, 8'(i) ^ 8'h3c);
    end
    ins(32'h2005ff00, 8'hc3);
  endtask

  task automatic t_lock;
    ins(32'h24000000, 8'h00);
    prog.instr(32'hace00000, r);
    ins(32'h24000000, 8'h00);
    for (int s = 1; s < 4; s++) begin
      prog.instr({`SFP_OP_ENABLE, `SFP_LOCK_TAG, 2'(s), 16'h0}, r);
      ins(32'h24000000, 8'((1 << (s + 2)) - 4));
      rdc(ST, 32'((1 << (s + 2)) - 3), 1'b0);
    end
  endtask

  task automatic t_abort;
    @(posedge clk_sys) pin <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rdc(ST, 32'h1c, 1'b0);
    @(posedge clk_sys) pin <= 1'b1;
    repeat (64) @(posedge clk_sys);
    ins(32'h24000000, 8'h00);
    wrc(`SFP_ADDR_CTRL, 32'h0, 1'b0);
    rdc(`SFP_ADDR_CTRL, 32'h0, 1'b0);
    ins(32'hac530000, 8'h00);
    rdc(ST, 32'h1c, 1'b0);
  endtask

  // Main sequence; reset is held for the first four cycles.
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_enable();
    t_erase();
    t_byte();
    t_page();
    t_lock();
    t_abort();
    test_done();
  end

  // Cuts a hung run short; the full sequence needs about 88200 cycles.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      mismatches++;
      test_done();
    end
  end
endmodule // tb_top
`default_nettype wire
